// *** design/dlic_top.sv ***
// module: dual level interrupt controller with register port
//
// Local design decision: strobed register access.
`timescale 1ns/100ps
//
// Contract
// (R1) normal request is OR of all 32 normal active status bits
// (R2) normal active status is raw source AND normal enable mask
// (R3) no priority encoding or vector generation; software picks the source
// (R4) raw source follows peripheral level; raw source register read-only
// (R5) enable bit 1 lets source raise request, 0 masks it
// (R6) writing zeros to enable mask never clears enable bits
// (R7) mask-clear write clears enable bits written as 1 only
// (R8) fast level has raw, enable, mask-clear, active registers like normal
// (R9) OR of fast active drives fast request and bit 0 of both sets
// (R10) setting a fast enable bit clears the same normal enable bit
// (R11) setting a normal enable bit clears the same fast enable bit
// (R12) a source may be disabled at both levels at once
// (R13) programmed interrupts bypass masks, write raw and active together
// (R14) programmed config bit 1 drives normal raw and active bit 1
// (R15) programmed config bit 2 drives fast bit 1; other bits reserved
// (R16) peripheral must hold its request long enough to be registered
// (R17) bit 0 is fast combined, bit 1 programmed, unused in enable
// (R18) sources on bits 2 to 19, bit 15 and 20 up reserved
// (R19) software saves active status on entering the service routine
// (R20) raw bit cleared only by the peripheral itself
// (R21) writes to read-only registers ignored, reserved bits read zero
module dlic_top
  import dlic_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // register port
  input wire logic [31:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // peripheral sources
  input wire logic [31:0] normalSrc,
  input wire logic [31:0] fastSrc,
  // core requests
  output logic normalIrq,
  output logic fastIrq
);
  import dlic_pkg::*;

  // ****************************************
  // registers
  // ****************************************
  logic [31:0] normalEnable_reg;
  logic [31:0] normalEnable_next;
  logic [31:0] fastEnable_reg;
  logic [31:0] fastEnable_next;
  logic [31:0] progCfg_reg;
  logic [31:0] normalRaw;
  logic [31:0] normalActive;
  logic [31:0] fastRaw;
  logic [31:0] fastActive;
  logic [31:0] rdMux;
  logic fastOr_reg;

  // write decodes
  logic wrNormEn;
  logic wrNormClr;
  logic wrFastEn;
  logic wrFastClr;
  logic wrProg;
  assign wrNormEn = regWr && (regAddr == NORMAL_ENABLE_MASK_OFS);
  assign wrNormClr = regWr && (regAddr == NORMAL_MASK_CLEAR_OFS);
  assign wrFastEn = regWr && (regAddr == FAST_ENABLE_MASK_OFS);
  assign wrFastClr = regWr && (regAddr == FAST_MASK_CLEAR_OFS);
  assign wrProg = regWr && (regAddr == PROG_INT_CONFIG_OFS);

  // ****************************************
  // enable masks with steering between levels
  // ****************************************
  // enable writes set bits in their own mask and clear the same bits in the other; zeros leave both masks alone
  always_comb begin
    normalEnable_next = normalEnable_reg;
    fastEnable_next = fastEnable_reg;
    if (wrNormEn) begin
      normalEnable_next = normalEnable_reg | (regWdata & ENABLE_MASK); // R5 R6
      fastEnable_next = fastEnable_reg & ~(regWdata & ENABLE_MASK); // R11
    end
    if (wrFastEn) begin
      fastEnable_next = fastEnable_reg | (regWdata & ENABLE_MASK); // R8
      normalEnable_next = normalEnable_reg & ~(regWdata & ENABLE_MASK); // R10
    end
    if (wrNormClr) begin
      normalEnable_next = normalEnable_reg & ~regWdata; // R7 R12
    end
    if (wrFastClr) begin
      fastEnable_next = fastEnable_reg & ~regWdata; // R7 R12
    end
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      normalEnable_reg <= ZERO_RST;
      fastEnable_reg <= ZERO_RST;
    end else begin
      normalEnable_reg <= normalEnable_next;
      fastEnable_reg <= fastEnable_next;
    end
  end

  // ****************************************
  // programmed interrupt config
  // ****************************************
  // only bits 1 and 2 are stored, the rest read zero
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      progCfg_reg <= ZERO_RST;
    end else if (wrProg) begin
      progCfg_reg <= regWdata & PROG_CFG_MASK; // R15 R21
    end
  end

  // ****************************************
  // the two levels
  // ****************************************
  // fast OR is computed from fast active and fed back as bit 0 of both sets
  dlic_level u_normal (
    .coreClk(core_clk),
    .nrst(nrst),
    .periphSrc(normalSrc), // R4 R18 R20
    .enableMask(normalEnable_reg), // R2
    .fastOr(fastOr_reg), // R9 R17
    .progBit(progCfg_reg[PROG_NORMAL_BIT]), // R13 R14
    .rawSource(normalRaw),
    .activeStatus(normalActive)
  );
  dlic_level u_fast (
    .coreClk(core_clk),
    .nrst(nrst),
    .periphSrc(fastSrc),
    .enableMask(fastEnable_reg),
    .fastOr(fastOr_reg), // R9
    .progBit(progCfg_reg[PROG_FAST_BIT]), // R15
    .rawSource(fastRaw),
    .activeStatus(fastActive)
  );

  // ****************************************
  // requests to the core
  // ****************************************
  // fast OR excludes bit 0 itself to avoid a self-holding loop
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fastOr_reg <= 1'b0;
      fastIrq <= 1'b0;
      normalIrq <= 1'b0;
    end else begin
      fastOr_reg <= |fastActive[31:1]; // R9
      fastIrq <= |fastActive[31:1]; // R9
      normalIrq <= |normalActive; // R1 R3
    end
  end

  // ****************************************
  // read port
  // ****************************************
  // unmapped and write-only addresses read zero; raw and status writes are ignored
  always_comb begin
    unique case (regAddr)
      NORMAL_ACTIVE_STATUS_OFS: rdMux = normalActive;
      NORMAL_RAW_SOURCE_OFS: rdMux = normalRaw;
      NORMAL_ENABLE_MASK_OFS: rdMux = normalEnable_reg;
      FAST_ACTIVE_STATUS_OFS: rdMux = fastActive;
      FAST_RAW_SOURCE_OFS: rdMux = fastRaw;
      FAST_ENABLE_MASK_OFS: rdMux = fastEnable_reg;
      PROG_INT_CONFIG_OFS: rdMux = progCfg_reg;
      default: rdMux = ZERO_RST; // R21
    endcase
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      regRdata <= ZERO_RST;
    end else if (regRd) begin
      regRdata <= rdMux;
    end else begin
      regRdata <= ZERO_RST;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_never_both_en: assert property (@(posedge core_clk) disable iff (!nrst) // R11
    (normalEnable_reg & fastEnable_reg) == 32'h0000_0000) else $error("source enabled at both levels");
  a_normal_req_or: assert property (@(posedge core_clk) disable iff (!nrst) // R1
    ##1 normalIrq == |$past(normalActive)) else $error("normal request not OR of active");
  a_active_and: assert property (@(posedge core_clk) disable iff (!nrst) // R2
    (normalActive & ENABLE_MASK) == (normalRaw & normalEnable_reg & ENABLE_MASK)) else $error("active not raw and mask");
  a_zero_no_clear: assert property (@(posedge core_clk) disable iff (!nrst) // R6
    (wrNormEn && !wrFastEn) |=> ((normalEnable_reg & $past(normalEnable_reg)) == $past(normalEnable_reg)))
    else $error("enable write cleared a bit");
  a_mask_clear: assert property (@(posedge core_clk) disable iff (!nrst) // R7
    wrNormClr |=> (normalEnable_reg == ($past(normalEnable_reg) & ~$past(regWdata)))) else $error("mask clear wrong");
  a_fast_steer: assert property (@(posedge core_clk) disable iff (!nrst) // R10
    wrFastEn |=> ((normalEnable_reg & $past(regWdata) & ENABLE_MASK) == 32'h0000_0000))
    else $error("fast enable kept normal bit");
  a_fast_req_or: assert property (@(posedge core_clk) disable iff (!nrst) // R9
    ##1 fastIrq == |$past(fastActive[31:1])) else $error("fast request not OR of active");
  a_prog_norm: assert property (@(posedge core_clk) disable iff (!nrst) // R14
    wrProg |-> ##2 (normalActive[PROG_BIT] == $past(regWdata[PROG_NORMAL_BIT], 2))) else $error("programmed bit lost");
  a_read_data: assert property (@(posedge core_clk) disable iff (!nrst) // R21
    !regRd |=> regRdata == 32'h0000_0000) else $error("read data outside read cycle");

  // ****************************************
  // checks: enable masks and steering
  // ****************************************
  // a normal enable write sets every written source bit
  a_norm_en_set: assert property (@(posedge core_clk) disable iff (!nrst) // R5
    wrNormEn |=> ((normalEnable_reg & $past(regWdata) & ENABLE_MASK) == ($past(regWdata) & ENABLE_MASK)))
    else $error("normal enable bit not set");

  // a fast enable write sets every written source bit
  a_fast_en_set: assert property (@(posedge core_clk) disable iff (!nrst) // R8
    wrFastEn |=> ((fastEnable_reg & $past(regWdata) & ENABLE_MASK) == ($past(regWdata) & ENABLE_MASK)))
    else $error("fast enable bit not set");

  // a normal enable write takes the same bits off the fast mask
  a_norm_steer: assert property (@(posedge core_clk) disable iff (!nrst) // R11
    wrNormEn |=> ((fastEnable_reg & $past(regWdata) & ENABLE_MASK) == 32'h0000_0000))
    else $error("normal enable kept fast bit");

  // zeros written to the fast enable must not drop a fast bit
  a_fast_zero_keep: assert property (@(posedge core_clk) disable iff (!nrst) // R6
    wrFastEn |=> ((fastEnable_reg & $past(fastEnable_reg)) == $past(fastEnable_reg)))
    else $error("fast enable write cleared a bit");

  // fast mask-clear drops only the bits written as one
  a_fast_clear: assert property (@(posedge core_clk) disable iff (!nrst) // R7
    wrFastClr |=> (fastEnable_reg == ($past(fastEnable_reg) & ~$past(regWdata))))
    else $error("fast mask clear wrong");

  // clearing one level never touches the other, so both may end up off
  a_norm_clr_iso: assert property (@(posedge core_clk) disable iff (!nrst) // R12
    wrNormClr |=> $stable(fastEnable_reg))
    else $error("normal clear touched fast mask");

  // the same holds the other way round
  a_fast_clr_iso: assert property (@(posedge core_clk) disable iff (!nrst) // R12
    wrFastClr |=> $stable(normalEnable_reg))
    else $error("fast clear touched normal mask");

  // without a mask write both masks hold, so no other path can disable a source
  a_mask_hold: assert property (@(posedge core_clk) disable iff (!nrst) // R6
    !(wrNormEn || wrNormClr || wrFastEn || wrFastClr) |=> ($stable(normalEnable_reg) && $stable(fastEnable_reg)))
    else $error("enable mask moved without a write");

  // bit 0, bit 1 and reserved positions can never be enabled
  a_en_reserved: assert property (@(posedge core_clk) disable iff (!nrst) // R17
    ((normalEnable_reg | fastEnable_reg) & ~ENABLE_MASK) == 32'h0000_0000)
    else $error("enable bit outside source field");

  // ****************************************
  // checks: raw sources, active status and requests
  // ****************************************
  // fast active is raw gated by the fast mask on the source field
  a_fast_active_and: assert property (@(posedge core_clk) disable iff (!nrst) // R8
    (fastActive & ENABLE_MASK) == (fastRaw & fastEnable_reg & ENABLE_MASK))
    else $error("fast active not raw and mask");

  // source bits of the raw view follow the peripheral level one cycle later; no register write reaches them
  a_norm_raw_follow: assert property (@(posedge core_clk) disable iff (!nrst) // R4 R20
    ##1 ((normalRaw & PERIPH_SRC_MASK) == ($past(normalSrc) & PERIPH_SRC_MASK)))
    else $error("normal raw does not follow source");

  // the same for the fast level
  a_fast_raw_follow: assert property (@(posedge core_clk) disable iff (!nrst) // R4 R8
    ##1 ((fastRaw & PERIPH_SRC_MASK) == ($past(fastSrc) & PERIPH_SRC_MASK)))
    else $error("fast raw does not follow source");

  // bit 15 and bits 20 up never show in either raw view
  a_raw_reserved: assert property (@(posedge core_clk) disable iff (!nrst) // R18
    ((normalRaw | fastRaw) & 32'hfff0_8000) == 32'h0000_0000)
    else $error("reserved raw bit set");

  // both register sets carry the same combined fast bit
  a_bit0_shared: assert property (@(posedge core_clk) disable iff (!nrst) // R9 R17
    normalRaw[FAST_OR_BIT] == fastRaw[FAST_OR_BIT])
    else $error("bit 0 differs between levels");

  // bit 0 lags the fast request by one cycle, the price of cutting the loop through it
  a_bit0_follow: assert property (@(posedge core_clk) disable iff (!nrst) // R9
    ##1 (fastRaw[FAST_OR_BIT] == $past(fastIrq)))
    else $error("bit 0 does not follow fast request");

  // the combined fast bit is not gated by either mask
  a_bit0_unmasked: assert property (@(posedge core_clk) disable iff (!nrst) // R9
    (normalActive[FAST_OR_BIT] == normalRaw[FAST_OR_BIT]) && (fastActive[FAST_OR_BIT] == fastRaw[FAST_OR_BIT]))
    else $error("bit 0 masked");

  // a fast request shows up in the normal request two cycles later through bit 0
  a_norm_req_fast: assert property (@(posedge core_clk) disable iff (!nrst) // R1 R9
    fastIrq |-> ##2 normalIrq)
    else $error("fast source missing from normal request");

  // no fast active bit means no fast request on the next cycle
  a_fast_idle: assert property (@(posedge core_clk) disable iff (!nrst) // R9
    !(|fastActive[31:1]) |=> !fastIrq)
    else $error("fast request without active bit");

  // ****************************************
  // checks: programmed interrupts
  // ****************************************
  // the fast programmed bit lands in fast active two cycles after the write
  a_prog_fast: assert property (@(posedge core_clk) disable iff (!nrst) // R15
    wrProg |-> ##2 (fastActive[PROG_BIT] == $past(regWdata[PROG_FAST_BIT], 2)))
    else $error("fast programmed bit lost");

  // the normal raw view carries the stored programmed bit
  a_prog_raw_norm: assert property (@(posedge core_clk) disable iff (!nrst) // R13 R14
    ##1 (normalRaw[PROG_BIT] == $past(progCfg_reg[PROG_NORMAL_BIT])))
    else $error("normal raw programmed bit wrong");

  // the fast raw view carries the other stored programmed bit
  a_prog_raw_fast: assert property (@(posedge core_clk) disable iff (!nrst) // R13 R15
    ##1 (fastRaw[PROG_BIT] == $past(progCfg_reg[PROG_FAST_BIT])))
    else $error("fast raw programmed bit wrong");

  // only the two level bits are ever stored
  a_prog_reserved: assert property (@(posedge core_clk) disable iff (!nrst) // R15 R21
    (progCfg_reg & ~PROG_CFG_MASK) == 32'h0000_0000)
    else $error("reserved programmed bit stored");

  // the config only moves on its own write, software alone raises and drops it
  a_prog_hold: assert property (@(posedge core_clk) disable iff (!nrst) // R13
    !wrProg |=> $stable(progCfg_reg))
    else $error("programmed config moved without a write");

  // ****************************************
  // checks: register port
  // ****************************************
  // mask-clear registers are write-only and read back zero
  a_read_clear_zero: assert property (@(posedge core_clk) disable iff (!nrst) // R21
    (regRd && ((regAddr == NORMAL_MASK_CLEAR_OFS) || (regAddr == FAST_MASK_CLEAR_OFS))) |=> (regRdata == 32'h0000_0000))
    else $error("mask clear read not zero");

  // a status read returns the value of the cycle the strobe was in
  a_read_status: assert property (@(posedge core_clk) disable iff (!nrst) // R2
    (regRd && (regAddr == NORMAL_ACTIVE_STATUS_OFS)) |=> (regRdata == $past(normalActive)))
    else $error("normal status read wrong");

  // the same for the fast status
  a_read_fast_status: assert property (@(posedge core_clk) disable iff (!nrst) // R8
    (regRd && (regAddr == FAST_ACTIVE_STATUS_OFS)) |=> (regRdata == $past(fastActive)))
    else $error("fast status read wrong");
endmodule : dlic_top

// *** design/dlic_pkg.sv ***
// package: register map, field positions and reset values of the dual level interrupt controller
package dlic_pkg;
  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [31:0] NORMAL_ACTIVE_STATUS_OFS = 32'hffff_0000;
  localparam logic [31:0] NORMAL_RAW_SOURCE_OFS = 32'hffff_0004;
  localparam logic [31:0] NORMAL_ENABLE_MASK_OFS = 32'hffff_0008;
  localparam logic [31:0] NORMAL_MASK_CLEAR_OFS = 32'hffff_000c;
  localparam logic [31:0] FAST_ACTIVE_STATUS_OFS = 32'hffff_0100;
  localparam logic [31:0] FAST_RAW_SOURCE_OFS = 32'hffff_0104;
  localparam logic [31:0] FAST_ENABLE_MASK_OFS = 32'hffff_0108;
  localparam logic [31:0] FAST_MASK_CLEAR_OFS = 32'hffff_010c;
  localparam logic [31:0] PROG_INT_CONFIG_OFS = 32'hffff_0010;
  // ****************************************
  // field positions and masks
  // ****************************************
  localparam int FAST_OR_BIT = 0;
  localparam int PROG_BIT = 1;
  localparam int PROG_NORMAL_BIT = 1;
  localparam int PROG_FAST_BIT = 2;
  // peripheral sources live on bits 2..19, bit 15 reserved
  localparam logic [31:0] PERIPH_SRC_MASK = 32'h000f_7ffc;
  localparam logic [31:0] PROG_CFG_MASK = 32'h0000_0006;
  // enable bits can exist only for peripheral sources
  localparam logic [31:0] ENABLE_MASK = 32'h000f_7ffc;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [31:0] ZERO_RST = 32'h0000_0000;
endpackage : dlic_pkg

// *** design/dlic_level.sv ***
// module: one interrupt level, raw source and active status with programmed bit merged in
`timescale 1ns/100ps
module dlic_level
  import dlic_pkg::*;
(
  // clock and reset
  input wire logic coreClk,
  input wire logic nrst,
  // inputs
  input wire logic [31:0] periphSrc,
  input wire logic [31:0] enableMask,
  input wire logic fastOr,
  input wire logic progBit,
  // outputs
  output logic [31:0] rawSource,
  output logic [31:0] activeStatus
);
  logic [31:0] rawNext;
  // raw view: peripheral levels, bit 0 is combined fast level, bit 1 programmed
  always_comb begin
    rawNext = periphSrc & PERIPH_SRC_MASK;
    rawNext[FAST_OR_BIT] = fastOr;
    rawNext[PROG_BIT] = progBit;
  end
  // registered once; the source must be held at least one cycle to be seen
  always_ff @(posedge coreClk or negedge nrst) begin
    if (!nrst) begin
      rawSource <= ZERO_RST;
    end else begin
      rawSource <= rawNext;
    end
  end
  // programmed bit and combined fast bit 0 bypass the mask, the rest is gated by it
  always_comb begin
    activeStatus = rawSource & enableMask;
    activeStatus[PROG_BIT] = rawSource[PROG_BIT];
    activeStatus[FAST_OR_BIT] = rawSource[FAST_OR_BIT];
  end
endmodule : dlic_level

// *** dv/dlic_src_model.sv ***
// file: peripheral interrupt source model for the controller bench
`timescale 1ns/100ps
module dlic_src_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // peripheral raise and own-clear commands
  input wire logic [31:0] setBits,
  input wire logic [31:0] clrBits,
  // interrupt levels toward the controller
  output logic [31:0] srcLvl
);
  // a level holds until the peripheral's own clear, so it always outlasts the latency
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) srcLvl <= 32'h0000_0000;
    else srcLvl <= (srcLvl | setBits) & ~clrBits;
  end
endmodule : dlic_src_model

// *** dv/dlic_top_test.sv ***
// file: self-checking bench of the dual level interrupt controller
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errorCnt++; \
  $display("mismatch %0t got %h exp %h", $time, g, e); end end
module dlic_top_test;
  import dlic_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [31:0] regAddr = '0, regWdata = '0, setBits = '0, clrBits = '0, src, regRdata;
  logic regWr = 1'b0, regRd = 1'b0, normalIrq, fastIrq;
  int errorCnt = 0, compares = 0, cyc = 0;
  always #50 core_clk = ~core_clk;
  dlic_src_model model (.core_clk(core_clk), .nrst(nrst), .setBits(setBits), .clrBits(clrBits),
    .srcLvl(src));
  // the fast side never sees bit 3, so swapped source ports show in the raw reads
  dlic_top dut (.core_clk(core_clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .normalSrc(src), .fastSrc(src & ~32'h0000_0008),
    .normalIrq(normalIrq), .fastIrq(fastIrq));
  // ****************************************
  // bus and source tasks
  // ****************************************
  // writes and source edges wait out the three-cycle request path before returning
  task automatic wr(input logic [31:0] a, d);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic ck(input logic [31:0] a, e);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    @(negedge core_clk);
    `CHK(regRdata, e)
  endtask : ck
  task automatic pulse(input logic [31:0] s, c);
    @(posedge core_clk);
    setBits <= s;
    clrBits <= c;
    @(posedge core_clk);
    setBits <= '0;
    clrBits <= '0;
    repeat (4) @(posedge core_clk);
  endtask : pulse
  task automatic finalReport;
    if (errorCnt == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finalReport
  // the sequence needs under two hundred cycles, so this ceiling only trips on a hang
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      errorCnt++;
      finalReport();
    end
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    ck(NORMAL_ENABLE_MASK_OFS, ZERO_RST);
    ck(FAST_ENABLE_MASK_OFS, ZERO_RST);
    // sources on bits 2 and 3 and reserved bit 15, nothing enabled yet
    pulse(32'h0000_800c, '0);
    ck(NORMAL_RAW_SOURCE_OFS, 32'h0000_000c);
    ck(FAST_RAW_SOURCE_OFS, 32'h0000_0004);
    ck(NORMAL_ACTIVE_STATUS_OFS, ZERO_RST);
    `CHK(normalIrq, 1'b0)
    wr(NORMAL_RAW_SOURCE_OFS, '1);
    ck(NORMAL_RAW_SOURCE_OFS, 32'h0000_000c);
    wr(NORMAL_ENABLE_MASK_OFS, '1);
    ck(NORMAL_ENABLE_MASK_OFS, ENABLE_MASK);
    `CHK(normalIrq, 1'b1)
    // the handler saves the active status first thing after the request
    ck(NORMAL_ACTIVE_STATUS_OFS, 32'h0000_000c);
    wr(NORMAL_ENABLE_MASK_OFS, '0);
    ck(NORMAL_ENABLE_MASK_OFS, ENABLE_MASK);
    wr(NORMAL_MASK_CLEAR_OFS, 32'h0000_0008);
    ck(NORMAL_ENABLE_MASK_OFS, 32'h000f_7ff4);
    ck(NORMAL_MASK_CLEAR_OFS, ZERO_RST);
    // steering bit 2 to the fast level takes it off the normal one
    wr(FAST_ENABLE_MASK_OFS, 32'h0000_0004);
    ck(NORMAL_ENABLE_MASK_OFS, 32'h000f_7ff0);
    ck(FAST_ACTIVE_STATUS_OFS, 32'h0000_0005);
    ck(NORMAL_ACTIVE_STATUS_OFS, 32'h0000_0001);
    `CHK({fastIrq, normalIrq}, 2'b11)
    // a fast mask-clear drops only the written bit and leaves the normal mask alone
    wr(FAST_ENABLE_MASK_OFS, 32'h0000_0014);
    wr(FAST_MASK_CLEAR_OFS, 32'h0000_0010);
    ck(FAST_ENABLE_MASK_OFS, 32'h0000_0004);
    ck(NORMAL_ENABLE_MASK_OFS, 32'h000f_7fe0);
    wr(NORMAL_ENABLE_MASK_OFS, 32'h0000_0004);
    ck(FAST_ENABLE_MASK_OFS, ZERO_RST);
    wr(NORMAL_MASK_CLEAR_OFS, '1);
    ck(NORMAL_ENABLE_MASK_OFS, ZERO_RST);
    ck(NORMAL_RAW_SOURCE_OFS, 32'h0000_000c);
    `CHK({fastIrq, normalIrq}, 2'b00)
    // programmed requests ignore the masks, which are all clear now
    wr(PROG_INT_CONFIG_OFS, 32'h0000_0002);
    ck(NORMAL_RAW_SOURCE_OFS, 32'h0000_000e);
    ck(NORMAL_ACTIVE_STATUS_OFS, 32'h0000_0002);
    `CHK({fastIrq, normalIrq}, 2'b01)
    wr(PROG_INT_CONFIG_OFS, '1);
    ck(PROG_INT_CONFIG_OFS, PROG_CFG_MASK);
    ck(FAST_ACTIVE_STATUS_OFS, 32'h0000_0003);
    ck(NORMAL_ACTIVE_STATUS_OFS, 32'h0000_0003);
    ck(FAST_RAW_SOURCE_OFS, 32'h0000_0007);
    wr(PROG_INT_CONFIG_OFS, '0);
    pulse('0, '1);
    ck(NORMAL_RAW_SOURCE_OFS, ZERO_RST);
    ck(32'hffff_0200, ZERO_RST);
    `CHK({fastIrq, normalIrq}, 2'b00)
    finalReport();
  end
endmodule : dlic_top_test
